/* File: io_port_pkg.sv */
// constants and types shared by the configurable i/o port block
package io_port_pkg;

  // port numbering, a..g
  localparam int NUM_PORTS = 7;
  localparam int PIN_W     = 8;
  localparam int PORT_A    = 0;
  localparam int PORT_B    = 1;
  localparam int PORT_C    = 2;
  localparam int PORT_D    = 3;
  localparam int PORT_E    = 4;
  localparam int PORT_F    = 5;
  localparam int PORT_G    = 6;
  localparam int NUM_IMC   = 3;

  // host register address: port number in the upper bits, register below
  localparam int ADDR_W       = 7;
  localparam int PORT_SEL_LSB = 4;
  localparam int PORT_SEL_W   = 3;
  localparam int REG_SEL_W    = 4;

  localparam logic [3:0] REG_PIN_LEVEL  = 4'h0;
  localparam logic [3:0] REG_OUT_VALUE  = 4'h1;
  localparam logic [3:0] REG_DIRECTION  = 4'h2;
  localparam logic [3:0] REG_DRIVE      = 4'h3;
  localparam logic [3:0] REG_ENABLE_OUT = 4'h4;
  localparam logic [3:0] REG_LOGIC_OUT  = 4'h5;
  localparam logic [3:0] REG_IMC_OUT    = 4'h6;

  // widths of usable pins per port
  localparam logic [7:0] MASK_FULL   = 8'hFF;
  localparam logic [7:0] MASK_PORT_D = 8'h0F;
  localparam logic [7:0] MASK_NONE   = 8'h00;

  // reset values of software registers
  localparam logic [7:0] OUT_RESET   = 8'h00;
  localparam logic [7:0] DIR_RESET   = 8'h00;
  localparam logic [7:0] DRIVE_RESET = 8'h00;

  // ports whose drive select picks open drain (a, b, e, g); others slew
  localparam logic [6:0] OPEN_DRAIN_PORTS = 7'h53;

  // input macrocell modes
  typedef enum logic [1:0] {
    IMC_PASS  = 2'b00,
    IMC_REG   = 2'b01,
    IMC_LATCH = 2'b10
  } imc_mode_t;

endpackage : io_port_pkg

/* File: io_port_block.sv */
// configurable i/o port block: seven ports, host registers, pin muxing
`timescale 1ns/1ps

module io_port_block (
  // clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     resetn,
  // host register port, synchronous to sys_clk
  input  wire logic [6:0]               reg_addr,
  input  wire logic [7:0]               reg_wdata,
  input  wire logic                     write_strobe_input,
  input  wire logic                     read_strobe,
  output logic      [7:0]               reg_rdata,
  // stored configuration
  input  wire logic                     cfg_bus16,
  input  wire logic [2:0][7:0]          cfg_array_sel,
  input  wire logic [2:0][7:0][1:0]     cfg_imc_mode,
  // logic array signals
  input  wire logic [7:0]               macrocell_group_a_outputs,
  input  wire logic [7:0]               macrocell_group_b_outputs,
  input  wire logic [7:0]               external_select_outputs,
  input  wire logic [2:0][7:0]          enable_product_term,
  input  wire logic [2:0]               imc_clock_term,
  output logic      [2:0][7:0]          input_macrocell,
  output logic      [3:0]               port_d_direct,
  // pins, a..g
  input  wire logic [6:0][7:0]          pin_in,
  output logic      [6:0][7:0]          pin_out,
  output logic      [6:0][7:0]          pin_oe,
  output logic      [6:0][7:0]          pin_fast_slew
);

  // usable software pins of a port; port f and 16-bit port g are bus pins
  function automatic logic [7:0] port_mask(input int p, input logic bus16);
    if (p == io_port_pkg::PORT_D) begin
      port_mask = io_port_pkg::MASK_PORT_D;
    end else if (p == io_port_pkg::PORT_F) begin
      port_mask = io_port_pkg::MASK_NONE;
    end else if (p == io_port_pkg::PORT_G && bus16) begin
      port_mask = io_port_pkg::MASK_NONE;
    end else begin
      port_mask = io_port_pkg::MASK_FULL;
    end
  endfunction : port_mask

  logic [6:0][7:0] out_q;
  logic [6:0][7:0] dir_q;
  logic [6:0][7:0] drive_q;
  logic [6:0][7:0] in_s1_q;
  logic [6:0][7:0] in_s2_q;
  logic [6:0][7:0] pin_out_q;
  logic [6:0][7:0] pin_oe_q;
  logic [6:0][7:0] slew_q;
  logic [2:0][7:0] imc_q;
  logic [2:0]      clk_term_q;
  logic [7:0]      rdata_q;

  logic [6:0][7:0] mask;
  logic [6:0][7:0] arr_sel;
  logic [6:0][7:0] arr_val;
  logic [6:0][7:0] arr_en;
  logic [6:0][7:0] val_d;
  logic [6:0][7:0] en_d;
  logic [6:0][7:0] pin_out_d;
  logic [6:0][7:0] pin_oe_d;
  logic [6:0][7:0] slew_d;
  logic [2:0]      term_rise;
  logic [2:0][7:0] imc_view;

  // host address split
  wire [2:0] port_sel = reg_addr[6:4];
  wire [3:0] reg_sel  = reg_addr[3:0];
  wire       wr_out   = write_strobe_input &&
                        reg_sel == io_port_pkg::REG_OUT_VALUE;
  wire       wr_dir   = write_strobe_input &&
                        reg_sel == io_port_pkg::REG_DIRECTION;
  wire       wr_drv   = write_strobe_input &&
                        reg_sel == io_port_pkg::REG_DRIVE;

  // per-port mux sources; only a..c have array outputs and enable terms
  always_comb begin
    for (int p = 0; p < io_port_pkg::NUM_PORTS; p++) begin
      mask[p]    = port_mask(p, cfg_bus16);
      arr_sel[p] = io_port_pkg::MASK_NONE;
      arr_val[p] = io_port_pkg::MASK_NONE;
      arr_en[p]  = io_port_pkg::MASK_NONE;
      if (p < io_port_pkg::NUM_IMC) begin
        arr_sel[p] = cfg_array_sel[p];
        arr_en[p]  = enable_product_term[p];
      end
    end
    arr_val[io_port_pkg::PORT_A] = macrocell_group_a_outputs;
    arr_val[io_port_pkg::PORT_B] = macrocell_group_b_outputs;
    arr_val[io_port_pkg::PORT_C] = external_select_outputs;
  end

  // output value, enable and drive style for every pin
  always_comb begin
    for (int p = 0; p < io_port_pkg::NUM_PORTS; p++) begin
      // array output overrides the data-out bit
      val_d[p] = (arr_sel[p] & arr_val[p]) | (~arr_sel[p] & out_q[p]);
      // driver on when enable term or direction bit
      en_d[p]  = (arr_en[p] | dir_q[p]) & mask[p];
      if (io_port_pkg::OPEN_DRAIN_PORTS[p]) begin
        // open drain only pulls low, never drives high
        pin_out_d[p] = val_d[p] & ~drive_q[p];
        pin_oe_d[p]  = en_d[p] & ~(drive_q[p] & val_d[p]);
        slew_d[p]    = io_port_pkg::MASK_NONE;
      end else begin
        pin_out_d[p] = val_d[p];
        pin_oe_d[p]  = en_d[p];
        slew_d[p]    = drive_q[p] & mask[p];
      end
    end
  end

  // host register writes; unusable bits stay zero
  always_ff @(posedge sys_clk) begin
    for (int p = 0; p < io_port_pkg::NUM_PORTS; p++) begin
      if (!resetn) begin
        out_q[p]   <= io_port_pkg::OUT_RESET;
        dir_q[p]   <= io_port_pkg::DIR_RESET;
        drive_q[p] <= io_port_pkg::DRIVE_RESET;
      end else if (port_sel == 3'(p)) begin
        if (wr_out) out_q[p] <= reg_wdata & mask[p];
        if (wr_dir) dir_q[p] <= reg_wdata & mask[p];
        if (wr_drv) drive_q[p] <= reg_wdata & mask[p];
      end
    end
  end

  // pin drivers come from flops so the pads see no decode glitches
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pin_out_q <= '0;
      pin_oe_q  <= '0;
      slew_q    <= '0;
    end else begin
      pin_out_q <= pin_out_d;
      pin_oe_q  <= pin_oe_d;
      slew_q    <= slew_d;
    end
  end

  // two-flop synchroniser on the pins; only in_s2_q is used by logic
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      in_s1_q <= '0;
      in_s2_q <= '0;
    end else begin
      in_s1_q <= pin_in;
      in_s2_q <= in_s1_q;
    end
  end

  // input macrocells: term rising edge clocks registers, high opens latch
  assign term_rise = imc_clock_term & ~clk_term_q;
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      clk_term_q <= '0;
      imc_q      <= '0;
    end else begin
      clk_term_q <= imc_clock_term;
      for (int p = 0; p < io_port_pkg::NUM_IMC; p++) begin
        for (int b = 0; b < io_port_pkg::PIN_W; b++) begin
          if (cfg_imc_mode[p][b] == io_port_pkg::IMC_REG &&
              term_rise[p]) begin
            imc_q[p][b] <= in_s2_q[p][b];
          end else if (cfg_imc_mode[p][b] == io_port_pkg::IMC_LATCH &&
                       imc_clock_term[p]) begin
            imc_q[p][b] <= in_s2_q[p][b];
          end
        end
      end
    end
  end

  // pass-through pins bypass the storage element
  always_comb begin
    for (int p = 0; p < io_port_pkg::NUM_IMC; p++) begin
      for (int b = 0; b < io_port_pkg::PIN_W; b++) begin
        imc_view[p][b] = (cfg_imc_mode[p][b] == io_port_pkg::IMC_PASS)
                         ? in_s2_q[p][b] : imc_q[p][b];
      end
    end
  end

  // array feeds: a-c through macrocells, d straight
  assign input_macrocell = imc_view;
  assign port_d_direct   = in_s2_q[io_port_pkg::PORT_D][3:0];

  // readback buffer: one source per read, unmapped reads zero
  wire       port_ok  = port_sel < 3'(io_port_pkg::NUM_PORTS);
  wire       imc_ok   = port_sel < 3'(io_port_pkg::NUM_IMC);
  wire [7:0] sel_mask = port_ok ? mask[port_sel] : io_port_pkg::MASK_NONE;
  wire [7:0] rd_mux   =
    !port_ok ? 8'h00 :
    reg_sel == io_port_pkg::REG_PIN_LEVEL  ?
      in_s2_q[port_sel] & sel_mask :
    reg_sel == io_port_pkg::REG_OUT_VALUE  ? out_q[port_sel] :
    reg_sel == io_port_pkg::REG_DIRECTION  ? dir_q[port_sel] :
    reg_sel == io_port_pkg::REG_DRIVE      ? drive_q[port_sel] :
    reg_sel == io_port_pkg::REG_ENABLE_OUT ? pin_oe_q[port_sel] :
    reg_sel == io_port_pkg::REG_LOGIC_OUT  ? arr_val[port_sel] :
    (reg_sel == io_port_pkg::REG_IMC_OUT && imc_ok) ?
      imc_view[port_sel[1:0]] : 8'h00;

  // read data is held until the next read strobe
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else if (read_strobe) begin
      rdata_q <= rd_mux;
    end
  end

  assign reg_rdata     = rdata_q;
  assign pin_out       = pin_out_q;
  assign pin_oe        = pin_oe_q;
  assign pin_fast_slew = slew_q;

  // checks
  a_reset_inputs: assert property (@(posedge sys_clk)
    !resetn |=> pin_oe == '0)
    else $error("pins not inputs after reset");

  a_reset_regs: assert property (@(posedge sys_clk)
    !resetn |=> dir_q == '0 && drive_q == '0 && out_q == '0)
    else $error("registers not at defaults after reset");

  a_oe_or_gate: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    (enable_product_term[0][0] || dir_q[0][0]) && !drive_q[0][0]
    |=> pin_oe[0][0])
    else $error("enable term or direction did not enable driver");

  a_dir_only: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    !enable_product_term[0][0] && !dir_q[0][0] |=> !pin_oe[0][0])
    else $error("driver on without term or direction");

  a_out_write: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    wr_out && port_sel == 3'(io_port_pkg::PORT_E) && !drive_q[4][0]
    |=> ##1 pin_out[4][0] == $past(reg_wdata[0], 2))
    else $error("data-out write did not reach pin");

  a_array_wins: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    cfg_array_sel[0][1] && !drive_q[0][1]
    |=> pin_out[0][1] == $past(macrocell_group_a_outputs[1]))
    else $error("array output did not override data-out");

  a_port_d_width: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    out_q[3][7:4] == 4'h0 && dir_q[3][7:4] == 4'h0)
    else $error("port d upper bits set");

  a_port_f_bus: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    pin_oe[5] == 8'h00)
    else $error("port f driven by port logic");

  a_level_read: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    read_strobe && reg_addr == 7'h10 |=> reg_rdata == $past(in_s2_q[1]))
    else $error("pin level readback wrong");

  a_enable_read: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    read_strobe && reg_addr == 7'h04 |=> reg_rdata == $past(pin_oe[0]))
    else $error("enable status readback wrong");

  a_imc_capture: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    cfg_imc_mode[2][0] == io_port_pkg::IMC_REG && term_rise[2]
    |=> imc_q[2][0] == $past(in_s2_q[2][0]))
    else $error("macrocell register missed its clock term");

endmodule : io_port_block

/* File: io_pin_world.sv */
// board model around the pins: pull-ups plus an outside driver per pin
`timescale 1ns/1ps

module io_pin_world (
  // device side of each pin
  input  wire logic [6:0][7:0] pin_out,
  input  wire logic [6:0][7:0] pin_oe,
  // outside drivers set by the bench
  input  wire logic [6:0][7:0] ext_val,
  input  wire logic [6:0][7:0] ext_en,
  // resolved pin level
  output logic      [6:0][7:0] pin_in
);
  // an undriven pin floats up to its pull-up, so open-drain pins
  // read back their data bit without a separate model
  always_comb begin
    for (int p = 0; p < 7; p++) begin
      for (int b = 0; b < 8; b++) begin
        if (pin_oe[p][b])
          pin_in[p][b] = pin_out[p][b];
        else
          pin_in[p][b] = ext_en[p][b] ? ext_val[p][b] : 1'b1;
      end
    end
  end
endmodule : io_pin_world

/* File: configurable_io_port_block_tb.sv */
// self-checking bench for the configurable i/o port block
`timescale 1ns/1ps

`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
  bad_count++; $display("Error t=%0t got %h exp %h", $time, a, e); end end

module configurable_io_port_block_tb;
  logic                 sys_clk = 1'b0;
  logic                 resetn  = 1'b0;
  logic [6:0]           reg_addr = 7'h00;
  logic [7:0]           reg_wdata = 8'h00;
  logic                 write_strobe_input = 1'b0;
  logic                 read_strobe = 1'b0;
  logic [7:0]           reg_rdata;
  logic                 cfg_bus16 = 1'b0;
  logic [2:0][7:0]      cfg_array_sel = '0;
  logic [2:0][7:0][1:0] cfg_imc_mode = '0;
  logic [7:0]           mc_a = 8'h00;
  logic [7:0]           mc_b = 8'h00;
  logic [7:0]           ecs = 8'h00;
  logic [2:0][7:0]      ept = '0;
  logic [2:0]           imc_clk = 3'h0;
  logic [2:0][7:0]      imc_q;
  logic [3:0]           pd_direct;
  logic [6:0][7:0]      pin_in, pin_out, pin_oe, pin_fast_slew;
  logic [6:0][7:0]      ext_val = '0;
  logic [6:0][7:0]      ext_en = '0;
  logic [7:0]           d;
  int                   bad_count = 0;
  int                   samples_checked = 0;

  // 25 MHz system clock
  always #20 sys_clk = ~sys_clk;

  io_port_block DUT (.sys_clk(sys_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .write_strobe_input(write_strobe_input), .read_strobe(read_strobe),
    .reg_rdata(reg_rdata), .cfg_bus16(cfg_bus16),
    .cfg_array_sel(cfg_array_sel), .cfg_imc_mode(cfg_imc_mode),
    .macrocell_group_a_outputs(mc_a), .macrocell_group_b_outputs(mc_b),
    .external_select_outputs(ecs), .enable_product_term(ept),
    .imc_clock_term(imc_clk), .input_macrocell(imc_q),
    .port_d_direct(pd_direct), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_fast_slew(pin_fast_slew));

  io_pin_world world (.pin_out(pin_out), .pin_oe(pin_oe),
    .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

  // host strobes change only on the falling edge, one cycle long
  task automatic wr(input logic [2:0] p, input logic [3:0] s,
                    input logic [7:0] v);
    @(negedge sys_clk);
    reg_addr = {p, s};
    reg_wdata = v;
    write_strobe_input = 1'b1;
    @(negedge sys_clk);
    write_strobe_input = 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] p, input logic [3:0] s,
                    output logic [7:0] v);
    @(negedge sys_clk);
    reg_addr = {p, s};
    read_strobe = 1'b1;
    @(negedge sys_clk);
    read_strobe = 1'b0;
    v = reg_rdata;
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : settle

  task automatic t_reset;
    `CHK(pin_oe, 56'h0)
    rd(3'd0, io_port_pkg::REG_DIRECTION, d); `CHK(d, 8'h00)
    rd(3'd4, io_port_pkg::REG_DRIVE, d); `CHK(d, 8'h00)
  endtask : t_reset

  // push-pull port c: device-driven bits read back at the pin
  task automatic t_gpio;
    wr(3'd2, io_port_pkg::REG_OUT_VALUE, 8'hA5);
    wr(3'd2, io_port_pkg::REG_DIRECTION, 8'hF0);
    wr(3'd4, io_port_pkg::REG_OUT_VALUE, 8'h81);
    settle(2);
    `CHK(pin_out[2], 8'hA5)
    `CHK(pin_out[4], 8'h81)
    `CHK(pin_oe[2], 8'hF0)
    rd(3'd2, io_port_pkg::REG_OUT_VALUE, d); `CHK(d, 8'hA5)
    rd(3'd2, io_port_pkg::REG_ENABLE_OUT, d); `CHK(d, 8'hF0)
    rd(3'd2, io_port_pkg::REG_PIN_LEVEL, d); `CHK(d, 8'hAF)
  endtask : t_gpio

  // outside levels, and the short port d
  task automatic t_level;
    ext_en[1] = 8'hFF;
    ext_val[1] = 8'h69;
    settle(4);
    rd(3'd1, io_port_pkg::REG_PIN_LEVEL, d); `CHK(d, 8'h69)
    `CHK(imc_q[1], 8'h69)
    wr(3'd3, io_port_pkg::REG_OUT_VALUE, 8'hFF);
    rd(3'd3, io_port_pkg::REG_OUT_VALUE, d); `CHK(d, 8'h0F)
    rd(3'd3, io_port_pkg::REG_PIN_LEVEL, d); `CHK(d, 8'h0F)
    `CHK(pd_direct, 4'hF)
  endtask : t_level

  task automatic t_drive;
    wr(3'd0, io_port_pkg::REG_OUT_VALUE, 8'h0F);
    wr(3'd0, io_port_pkg::REG_DIRECTION, 8'hFF);
    wr(3'd0, io_port_pkg::REG_DRIVE, 8'hFF);
    wr(3'd2, io_port_pkg::REG_DRIVE, 8'hFF);
    settle(2);
    `CHK(pin_out[0], 8'h00)
    `CHK(pin_oe[0], 8'hF0)
    `CHK(pin_fast_slew[2], 8'hFF)
    `CHK(pin_out[2], 8'hA5)
    rd(3'd0, io_port_pkg::REG_PIN_LEVEL, d); `CHK(d, 8'h0F)
  endtask : t_drive

  // array-owned pins ignore data-out; enable is term or direction
  task automatic t_array;
    wr(3'd0, io_port_pkg::REG_DRIVE, 8'h00);
    wr(3'd0, io_port_pkg::REG_DIRECTION, 8'h00);
    cfg_array_sel[0] = 8'hFF;
    cfg_array_sel[1] = 8'hFF;
    cfg_array_sel[2] = 8'hFF;
    mc_a = 8'h3C;
    mc_b = 8'hC3;
    ecs = 8'h5A;
    ept[0] = 8'h0F;
    wr(3'd0, io_port_pkg::REG_OUT_VALUE, 8'hFF);
    settle(2);
    `CHK(pin_out[0], 8'h3C)
    `CHK(pin_oe[0], 8'h0F)
    `CHK(pin_out[2], 8'h5A)
    `CHK(pin_out[1], 8'hC3)
    rd(3'd1, io_port_pkg::REG_LOGIC_OUT, d); `CHK(d, 8'hC3)
    wr(3'd0, io_port_pkg::REG_DIRECTION, 8'h30);
    settle(2);
    `CHK(pin_oe[0], 8'h3F)
    `CHK(pin_out[0], 8'h3C)
    cfg_array_sel = '0;
  endtask : t_array

  task automatic t_bus16;
    cfg_bus16 = 1'b1;
    wr(3'd6, io_port_pkg::REG_DIRECTION, 8'hFF);
    wr(3'd5, io_port_pkg::REG_DIRECTION, 8'hFF);
    settle(2);
    `CHK(pin_oe[6], 8'h00)
    `CHK(pin_oe[5], 8'h00)
    rd(3'd6, io_port_pkg::REG_DIRECTION, d); `CHK(d, 8'h00)
    cfg_bus16 = 1'b0;
    rd(3'd7, io_port_pkg::REG_OUT_VALUE, d); `CHK(d, 8'h00)
    rd(3'd0, 4'hF, d); `CHK(d, 8'h00)
  endtask : t_bus16

  // registered macrocell holds what the term's rising edge took; a latch
  // follows its pins only while the term is high
  task automatic t_imc;
    // release port a first, else the device outvotes the outside driver
    ept[0] = 8'h00;
    wr(3'd0, io_port_pkg::REG_DIRECTION, 8'h00);
    cfg_imc_mode[0] = {8{io_port_pkg::IMC_REG}};
    cfg_imc_mode[1] = {8{io_port_pkg::IMC_LATCH}};
    cfg_imc_mode[2] = {8{io_port_pkg::IMC_REG}};
    ext_en[0] = 8'hFF;
    ext_val[0] = 8'h55;
    settle(4);
    `CHK(imc_q[1], 8'h00)
    imc_clk = 3'h7;
    settle(4);
    ext_val[0] = 8'hAA;
    ext_val[1] = 8'h96;
    settle(4);
    `CHK(imc_q[0], 8'h55)
    `CHK(imc_q[1], 8'h96)
    `CHK(imc_q[2], 8'hAF)
    rd(3'd0, io_port_pkg::REG_IMC_OUT, d); `CHK(d, 8'h55)
    imc_clk = 3'h0;
    ext_val[1] = 8'h11;
    settle(4);
    `CHK(imc_q[1], 8'h96)
  endtask : t_imc

  // a second reset in mid-run puts the port registers back to defaults
  task automatic t_rereset;
    resetn = 1'b0;
    settle(2);
    resetn = 1'b1;
    `CHK(pin_oe, 56'h0)
    rd(3'd2, io_port_pkg::REG_OUT_VALUE, d); `CHK(d, 8'h00)
    rd(3'd2, io_port_pkg::REG_DIRECTION, d); `CHK(d, 8'h00)
    rd(3'd2, io_port_pkg::REG_DRIVE, d); `CHK(d, 8'h00)
  endtask : t_rereset

  task automatic summarize;
    $display("checks %0d errors %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  // a hung run counts as a mismatch
  initial begin
    repeat (5000) @(posedge sys_clk);
    bad_count++;
    summarize();
  end

  initial begin
    repeat (3) @(negedge sys_clk);
    resetn = 1'b1;
    t_reset();
    t_gpio();
    t_level();
    t_drive();
    t_array();
    t_bus16();
    t_imc();
    t_rereset();
    summarize();
  end
endmodule : configurable_io_port_block_tb
